/* pcfp_programmer.sv */
// Implementation choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - Keys 1,2,3,5 select gain, duty, carrier, lock.
// - Addressing begins when second high pulse falls.
// - Each mid adds one, saturating at maximum.
// - Value is fuse sum times step size.
// - Code drives the DAC after every pulse.
// - Supply cycle clears unblown bits, keeps blown.
// - Blow order never changes final pattern.
// - Gain field is 8 bits wide.
// - Pulses are low-high-low or low-mid-low.
// - Initial state ignores mids, high enters selection.
// - High pulse while addressing blows addressed bits.
// - Lock at register 5 code 512 refuses programming.
module pcfp_programmer #(
  parameter int MIN_CYCLES = pcfp_pkg::MIN_PULSE_CYCLES
) (
  // Clock and supply reset.
  input wire logic clk_sys,
  input wire logic rst_b,
  // Factory erase of the fuse store.
  input wire logic nvErase,
  // Comparator level of the shared output pin.
  input wire logic [1:0] sharedOutputPinLevel,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Parameter values and DAC code.
  output logic [15:0] gainValue,
  output logic coarseDutyEn,
  output logic [15:0] dutyValue,
  output logic [15:0] carrierValue,
  output logic calTestEn,
  output logic [9:0] dacCode,
  output logic deviceLocked
);

  // Map a key to its fuse slot.
  function automatic logic [1:0] keySlot(input logic [2:0] key);
    case (key)
      pcfp_pkg::KEY_GAIN: keySlot = pcfp_pkg::SLOT_GAIN;
      pcfp_pkg::KEY_DUTY: keySlot = pcfp_pkg::SLOT_DUTY;
      pcfp_pkg::KEY_CARRIER: keySlot = pcfp_pkg::SLOT_CARRIER;
      default: keySlot = pcfp_pkg::SLOT_LOCK;
    endcase
  endfunction

  // True when a key names a defined register.
  function automatic logic keyValid(input logic [2:0] key);
    keyValid = (key == pcfp_pkg::KEY_GAIN) || (key == pcfp_pkg::KEY_DUTY) ||
               (key == pcfp_pkg::KEY_CARRIER) || (key == pcfp_pkg::KEY_LOCK);
  endfunction

  // Largest code for a slot.
  function automatic logic [9:0] slotMax(input logic [1:0] slot);
    case (slot)
      pcfp_pkg::SLOT_GAIN: slotMax = pcfp_pkg::MAX_CODE_GAIN;
      pcfp_pkg::SLOT_DUTY: slotMax = pcfp_pkg::MAX_CODE_DUTY;
      pcfp_pkg::SLOT_CARRIER: slotMax = pcfp_pkg::MAX_CODE_CARRIER;
      default: slotMax = pcfp_pkg::LOCK_CODE;
    endcase
  endfunction

  // Scale an 8-bit field by its step.
  function automatic logic [15:0] applyStep(input logic [7:0] field, input logic [7:0] step);
    applyStep = 16'(field * step);
  endfunction

  // Fuse store link.
  pcfp_fuse_if fuseLink ();

  // Fuse store instance.
  pcfp_fuse_store fuseStore (
    .clk_sys(clk_sys),
    .nvErase(nvErase),
    .fuse(fuseLink.store)
  );

  // Pulse detector state.
  logic [1:0] peakLevel_q;
  logic [pcfp_pkg::DUR_W-1:0] activeCnt_q;
  logic midPulse_q;
  logic highPulse_q;

  // Sequencer state.
  pcfp_pkg::pcfp_state_type state_q;
  logic [2:0] key_q;
  logic [1:0] slot_q;
  logic [9:0] tryCode_q;
  logic blowStb_q;

  // Software control.
  logic progEnable_q;

  // Lock taken from the blown lock fuse.
  logic lockBlown;
  assign lockBlown = fuseLink.blownFields[pcfp_pkg::SLOT_LOCK][pcfp_pkg::LOCK_BIT];

  // Measure each excursion away from low and note its peak level. A pulse counts only when
  // it returns to low after the least active time, so short glitches on the supply never
  // advance the sequence; the rest of the timing is left to the programmer.
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      peakLevel_q <= pcfp_pkg::LEVEL_LOW;
      activeCnt_q <= '0;
      midPulse_q <= 1'b0;
      highPulse_q <= 1'b0;
    end else begin
      midPulse_q <= 1'b0;
      highPulse_q <= 1'b0;
      if (sharedOutputPinLevel == pcfp_pkg::LEVEL_LOW) begin
        // Falling edge ends a pulse; classify it by the highest level reached.
        if (activeCnt_q >= pcfp_pkg::DUR_W'(MIN_CYCLES)) begin
          midPulse_q <= (peakLevel_q == pcfp_pkg::LEVEL_MID);
          highPulse_q <= (peakLevel_q == pcfp_pkg::LEVEL_HIGH);
        end
        peakLevel_q <= pcfp_pkg::LEVEL_LOW;
        activeCnt_q <= '0;
      end else begin
        // Still active: count time and keep the peak.
        if (sharedOutputPinLevel == pcfp_pkg::LEVEL_HIGH) begin
          peakLevel_q <= pcfp_pkg::LEVEL_HIGH;
        end else if (peakLevel_q == pcfp_pkg::LEVEL_LOW) begin
          peakLevel_q <= pcfp_pkg::LEVEL_MID;
        end
        if (activeCnt_q != '1) begin
          activeCnt_q <= activeCnt_q + 1'b1;
        end
      end
    end
  end

  // Programming sequence. The supply reset returns here to the initial state and drops the
  // try code, which is how unblown bits clear on a power cycle.
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      state_q <= pcfp_pkg::ST_INITIAL;
      key_q <= '0;
      slot_q <= pcfp_pkg::SLOT_GAIN;
      tryCode_q <= '0;
      blowStb_q <= 1'b0;
    end else begin
      blowStb_q <= 1'b0;
      case (state_q)
        pcfp_pkg::ST_INITIAL: begin
          // Mid pulses are ignored here; a locked part never leaves.
          if (highPulse_q && progEnable_q && !lockBlown) begin
            state_q <= pcfp_pkg::ST_SELECT;
            key_q <= '0;
          end
        end
        pcfp_pkg::ST_SELECT: begin
          if (midPulse_q) begin
            // Key counts up and holds at its top rather than wrapping onto a valid key.
            if (key_q != '1) begin
              key_q <= key_q + 1'b1;
            end
          end else if (highPulse_q) begin
            // The pulse is seen at its falling edge, so addressing starts there.
            if (keyValid(key_q)) begin
              state_q <= pcfp_pkg::ST_ADDRESS;
              slot_q <= keySlot(key_q);
              tryCode_q <= '0;
            end else begin
              state_q <= pcfp_pkg::ST_HALT;
            end
          end
        end
        pcfp_pkg::ST_ADDRESS: begin
          if (midPulse_q) begin
            // One step per pulse, held at the register's largest code.
            if (tryCode_q < slotMax(slot_q)) begin
              tryCode_q <= tryCode_q + 1'b1;
            end
          end else if (highPulse_q) begin
            // Blow the addressed bits, then wait for a supply cycle.
            blowStb_q <= 1'b1;
            state_q <= pcfp_pkg::ST_HALT;
          end
        end
        pcfp_pkg::ST_HALT: begin
          // Only the supply reset leaves this state.
          state_q <= pcfp_pkg::ST_HALT;
        end
        default: begin
          state_q <= pcfp_pkg::ST_INITIAL;
        end
      endcase
    end
  end

  // Blow request to the fuse store.
  assign fuseLink.blowStb = blowStb_q;
  assign fuseLink.blowSlot = slot_q;
  assign fuseLink.blowBits = tryCode_q;

  // Effective field: blown bits plus the bits activated by addressing, when addressed.
  function automatic logic [9:0] effField(input logic [1:0] slot, input logic [9:0] blown,
                                          input logic [1:0] selSlot, input logic [9:0] tryCode,
                                          input logic tryOn);
    effField = blown | ((tryOn && slot == selSlot) ? tryCode : 10'h000);
  endfunction

  // Try code applies while addressing and after a blow until the supply cycles.
  logic tryOn;
  assign tryOn = (state_q == pcfp_pkg::ST_ADDRESS) ||
                 ((state_q == pcfp_pkg::ST_HALT) && keyValid(key_q));

  // Combined fields.
  logic [9:0] gainField;
  logic [9:0] dutyField;
  logic [9:0] carrierField;
  assign gainField = effField(pcfp_pkg::SLOT_GAIN, fuseLink.blownFields[pcfp_pkg::SLOT_GAIN],
                              slot_q, tryCode_q, tryOn);
  assign dutyField = effField(pcfp_pkg::SLOT_DUTY, fuseLink.blownFields[pcfp_pkg::SLOT_DUTY],
                              slot_q, tryCode_q, tryOn);
  assign carrierField = effField(pcfp_pkg::SLOT_CARRIER, fuseLink.blownFields[pcfp_pkg::SLOT_CARRIER],
                                 slot_q, tryCode_q, tryOn);

  // Parameter outputs, registered. The gain keeps its low 8 bits and bit 8 is the coarse
  // duty switch; the duty and carrier scaling only covers their low byte.
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      gainValue <= '0;
      coarseDutyEn <= 1'b0;
      dutyValue <= '0;
      carrierValue <= '0;
      calTestEn <= 1'b0;
      deviceLocked <= 1'b0;
    end else begin
      gainValue <= applyStep(gainField[pcfp_pkg::GAIN_W-1:0], pcfp_pkg::STEP_GAIN);
      coarseDutyEn <= gainField[pcfp_pkg::COARSE_BIT];
      dutyValue <= applyStep(dutyField[7:0], pcfp_pkg::STEP_DUTY);
      carrierValue <= applyStep(carrierField[7:0], pcfp_pkg::STEP_CARRIER);
      calTestEn <= carrierField[pcfp_pkg::COARSE_BIT];
      deviceLocked <= lockBlown;
    end
  end

  // DAC follows the addressed field after every pulse so it can be measured.
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      dacCode <= '0;
    end else begin
      case (slot_q)
        pcfp_pkg::SLOT_GAIN: dacCode <= gainField;
        pcfp_pkg::SLOT_DUTY: dacCode <= dutyField;
        pcfp_pkg::SLOT_CARRIER: dacCode <= carrierField;
        default: dacCode <= fuseLink.blownFields[pcfp_pkg::SLOT_LOCK] | (tryOn ? tryCode_q : 10'h000);
      endcase
    end
  end

  // Register decode for reads.
  logic [31:0] readMux;
  logic addrHit;
  always_comb begin
    readMux = 32'h00000000;
    addrHit = 1'b1;
    case (paddr)
      pcfp_pkg::OFF_CTRL: readMux[pcfp_pkg::CTRL_ENABLE_BIT] = progEnable_q;
      pcfp_pkg::OFF_STATUS: begin
        readMux[pcfp_pkg::STATUS_STATE_POS +: 3] = state_q;
        readMux[pcfp_pkg::STATUS_KEY_POS +: 3] = key_q;
        readMux[pcfp_pkg::STATUS_LOCK_POS] = lockBlown;
      end
      pcfp_pkg::OFF_TRY: readMux[9:0] = tryCode_q;
      pcfp_pkg::OFF_BLOWN_GAIN: readMux[9:0] = fuseLink.blownFields[pcfp_pkg::SLOT_GAIN];
      pcfp_pkg::OFF_BLOWN_DUTY: readMux[9:0] = fuseLink.blownFields[pcfp_pkg::SLOT_DUTY];
      pcfp_pkg::OFF_BLOWN_CARRIER: readMux[9:0] = fuseLink.blownFields[pcfp_pkg::SLOT_CARRIER];
      pcfp_pkg::OFF_BLOWN_LOCK: readMux[9:0] = fuseLink.blownFields[pcfp_pkg::SLOT_LOCK];
      default: addrHit = 1'b0;
    endcase
  end

  // APB answer: one wait state so that data and error come straight from flops.
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      pready <= 1'b0;
      prdata <= '0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && penable && !pready;
      if (psel && penable && !pready) begin
        prdata <= pwrite ? 32'h00000000 : readMux;
        pslverr <= !addrHit;
      end else begin
        pslverr <= 1'b0;
      end
    end
  end

  // Control register write, taken at the completing edge. Only the control word is writable.
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      progEnable_q <= pcfp_pkg::CTRL_ENABLE_RESET;
    end else if (psel && penable && pready && pwrite && paddr == pcfp_pkg::OFF_CTRL) begin
      progEnable_q <= pwdata[pcfp_pkg::CTRL_ENABLE_BIT];
    end
  end

endmodule
`default_nettype wire

/* pcfp_pkg.sv */
// Shared constants and types of the pulse-count fuse programmer.
package pcfp_pkg;

  // Clock rate and the least pulse and gap time on the programming pin.
  localparam int CLK_MHZ = 125;
  localparam int T_MIN_PULSE_US = 40;
  // Least time rounds up to whole cycles.
  localparam int MIN_PULSE_CYCLES = (T_MIN_PULSE_US * CLK_MHZ * 1000 + 999) / 1000;

  // Width of the pulse duration counter; it saturates, so it only needs to exceed the minimum.
  localparam int DUR_W = 16;

  // Level codes delivered by the pin's level comparators.
  localparam logic [1:0] LEVEL_LOW = 2'h0;
  localparam logic [1:0] LEVEL_MID = 2'h1;
  localparam logic [1:0] LEVEL_HIGH = 2'h2;

  // Code and key widths.
  localparam int CODE_W = 10;
  localparam int KEY_W = 3;
  localparam int GAIN_W = 8;
  localparam int NUM_FIELDS = 4;

  // Keys that name a register.
  localparam logic [2:0] KEY_GAIN = 3'h1;
  localparam logic [2:0] KEY_DUTY = 3'h2;
  localparam logic [2:0] KEY_CARRIER = 3'h3;
  localparam logic [2:0] KEY_LOCK = 3'h5;

  // Field slots in the fuse store.
  localparam logic [1:0] SLOT_GAIN = 2'h0;
  localparam logic [1:0] SLOT_DUTY = 2'h1;
  localparam logic [1:0] SLOT_CARRIER = 2'h2;
  localparam logic [1:0] SLOT_LOCK = 2'h3;

  // Largest code each register accepts.
  localparam logic [9:0] MAX_CODE_GAIN = 10'h1FF;
  localparam logic [9:0] MAX_CODE_DUTY = 10'h1FF;
  localparam logic [9:0] MAX_CODE_CARRIER = 10'h1FF;
  localparam logic [9:0] LOCK_CODE = 10'h200;
  localparam int LOCK_BIT = 9;
  localparam int COARSE_BIT = 8;

  // Step sizes applied to a code to form the parameter value.
  localparam logic [7:0] STEP_GAIN = 8'h01;
  localparam logic [7:0] STEP_DUTY = 8'h01;
  localparam logic [7:0] STEP_CARRIER = 8'h01;

  // Register byte offsets on the bus.
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_TRY = 8'h08;
  localparam logic [7:0] OFF_BLOWN_GAIN = 8'h0C;
  localparam logic [7:0] OFF_BLOWN_DUTY = 8'h10;
  localparam logic [7:0] OFF_BLOWN_CARRIER = 8'h14;
  localparam logic [7:0] OFF_BLOWN_LOCK = 8'h18;

  // Control register layout and reset value.
  localparam int CTRL_ENABLE_BIT = 0;
  localparam logic CTRL_ENABLE_RESET = 1'b1;

  // Status register layout.
  localparam int STATUS_STATE_POS = 0;
  localparam int STATUS_KEY_POS = 4;
  localparam int STATUS_LOCK_POS = 8;

  // States of the programming sequence.
  typedef enum logic [2:0] {
    ST_INITIAL,
    ST_SELECT,
    ST_ADDRESS,
    ST_HALT
  } pcfp_state_type;

endpackage

/* pcfp_fuse_if.sv */
`timescale 1ns/1ps
`default_nettype none
// Link between the sequencer and the fuse store.
interface pcfp_fuse_if;
  // Blow request: one-cycle strobe, slot and bits to blow.
  logic blowStb;
  logic [1:0] blowSlot;
  logic [9:0] blowBits;
  // Registered copy of every blown field.
  logic [3:0][9:0] blownFields;

  modport sequencer (output blowStb, output blowSlot, output blowBits, input blownFields);
  modport store (input blowStb, input blowSlot, input blowBits, output blownFields);
endinterface
`default_nettype wire

/* pcfp_fuse_store.sv */
`timescale 1ns/1ps
`default_nettype none
// Fuse store. Blown bits are not touched by the supply reset; only a factory erase clears them.
module pcfp_fuse_store (
  // Clock.
  input wire logic clk_sys,
  // Factory erase, a blank part in simulation.
  input wire logic nvErase,
  // Sequencer side.
  pcfp_fuse_if.store fuse
);

  // Fuse words; they survive power cycles.
  logic [3:0][9:0] fuseMem;

  // A blow only ever sets bits, so the result never depends on order.
  always_ff @(posedge clk_sys) begin
    if (nvErase) begin
      fuseMem <= '0;
    end else if (fuse.blowStb) begin
      fuseMem[fuse.blowSlot] <= fuseMem[fuse.blowSlot] | fuse.blowBits;
    end
  end

  // Read data come out of a register.
  always_ff @(posedge clk_sys) begin
    fuse.blownFields <= fuseMem;
  end

endmodule
`default_nettype wire

/* pcfp_programmer_chk.sv */
`timescale 1ns/1ps
`default_nettype none
// Watches the programmer's ports for bus and pin slips.
module pcfp_programmer_chk #(
  parameter int MIN_CYCLES = 8
) (
  // Clock and supply reset.
  input wire logic clk_sys,
  input wire logic rst_b,
  // Pin level and bus request.
  input wire logic [1:0] sharedOutputPinLevel,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  // Bus answer and parameter outputs.
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [15:0] gainValue,
  input wire logic [15:0] dutyValue,
  input wire logic [15:0] carrierValue,
  input wire logic [9:0] dacCode,
  input wire logic deviceLocked
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_b);

  // An access phase still waiting for its answer.
  sequence sAccess;
    psel && penable && !pready;
  endsequence
  // A pulse active for four cycles running.
  sequence sActive;
    (sharedOutputPinLevel != pcfp_pkg::LEVEL_LOW) [*4];
  endsequence

  // Cycles the pin has been away from low, held at its top so it never wraps.
  logic [15:0] actCnt_q;
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      actCnt_q <= '0;
    end else if (sharedOutputPinLevel == pcfp_pkg::LEVEL_LOW) begin
      actCnt_q <= '0;
    end else if (actCnt_q != '1) begin
      actCnt_q <= actCnt_q + 16'h0001;
    end
  end
  // A pulse that returns to low before the least active time has passed.
  sequence sShortEnd;
    (sharedOutputPinLevel == pcfp_pkg::LEVEL_LOW) && (actCnt_q != 16'h0000) && (actCnt_q < 16'(MIN_CYCLES));
  endsequence

  pready_pulse_a: assert property (pready |=> !pready)
    else $error("pready stood too long");
  pready_wait_a: assert property (sAccess |=> pready)
    else $error("no answer after access");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  unmapped_err_a: assert property (sAccess ##0 (paddr > 8'h18) |=> pslverr)
    else $error("unmapped access not refused");
  err_data_a: assert property (pslverr && !pwrite |-> prdata == 32'h0)
    else $error("refused read returned data");
  lock_sticky_a: assert property (deviceLocked |=> deviceLocked)
    else $error("lock dropped");
  // The DAC code and gain value only move in the gap after a pulse ends, never mid-pulse.
  dac_quiet_a: assert property (sActive |-> $stable(dacCode) && $stable(gainValue))
    else $error("outputs moved during a pulse");
  // A glitch shorter than the least pulse time must leave the measured code alone.
  short_ignored_a: assert property (sShortEnd |=> $stable(dacCode) [*4])
    else $error("short pulse moved the code");
  code_max_a: assert property (dacCode[9] |-> dacCode[8:0] == 9'h0)
    else $error("code above its maximum");
  field_width_a: assert property ((gainValue | dutyValue | carrierValue) < 16'h100)
    else $error("field wider than eight bits");
endmodule
bind pcfp_programmer pcfp_programmer_chk #(.MIN_CYCLES(MIN_CYCLES)) chk (.clk_sys, .rst_b,
  .sharedOutputPinLevel, .psel, .penable, .pwrite, .paddr, .prdata, .pready, .pslverr,
  .gainValue, .dutyValue, .carrierValue, .dacCode, .deviceLocked);
`default_nettype wire

/* pcfp_prog_supply.sv */
`timescale 1ns/1ps
`default_nettype none
// Programming supply: shapes level pulses on the shared output pin.
module pcfp_prog_supply (
  // Clock.
  input wire logic clk_sys,
  // Level seen by the pin comparators.
  output var logic [1:0] pinLevel
);
  // The pin rests low between pulses.
  initial pinLevel = pcfp_pkg::LEVEL_LOW;
  // One pulse of len cycles, then a low gap so pulses stay separate.
  task automatic send(input logic [1:0] lvl, input int len, input int gap);
    @(posedge clk_sys);
    pinLevel <= lvl;
    repeat (len) @(posedge clk_sys);
    pinLevel <= pcfp_pkg::LEVEL_LOW;
    repeat (gap) @(posedge clk_sys);
  endtask
endmodule
`default_nettype wire

/* tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
// Self-checking bench: a model follows every pulse and bus read.
module tb_top;
  // Short minimum pulse keeps long code trains quick.
  localparam int MIN = 8;
  logic clk_sys = 1'h0;
  logic rst_b = 1'h0;
  logic nvErase = 1'h1;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [15:0] gainValue;
  logic coarseDutyEn;
  logic [15:0] dutyValue;
  logic [15:0] carrierValue;
  logic calTestEn;
  logic [9:0] dacCode;
  logic deviceLocked;
  wire [1:0] pinLevel;
  // Score and model state; mSel is -1 while no slot is chosen.
  int mismatches = 0;
  int numChecks = 0;
  int mState;
  int mKey;
  int mTry;
  int mSel;
  int mEn;
  int blown [4] = '{default: 0};
  int code;
  int n;

  always #4 clk_sys = ~clk_sys;

  pcfp_prog_supply src (.clk_sys, .pinLevel);
  pcfp_programmer #(.MIN_CYCLES(MIN)) dut (.clk_sys, .rst_b, .nvErase, .sharedOutputPinLevel(pinLevel),
    .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .gainValue, .coarseDutyEn,
    .dutyValue, .carrierValue, .calTestEn, .dacCode, .deviceLocked);

  // Effective field: blown fuses plus the live code of the chosen slot.
  function automatic int eff(input int s);
    return blown[s] | ((mSel == s) ? mTry : 0);
  endfunction

  // One counted comparison.
  task automatic cmp(input string what, input logic [31:0] seen, input int exp);
    numChecks++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  // One bus transfer, held until pready is sampled high.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    @(posedge clk_sys);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'h1;
    do @(posedge clk_sys); while (pready !== 1'h1);
    r = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  // Masked register read with the expected error flag.
  task automatic rd(input logic [7:0] a, input int exp, input int err = 0, input int m = -1);
    logic [31:0] r;
    logic e;
    apb(1'h0, a, 32'h0, r, e);
    cmp("prdata", r & m, exp);
    cmp("pslverr", e, err);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'h1, a, d, r, e);
    cmp("pslverr", e, 0);
  endtask

  // All parameter outputs and the state against the model.
  task automatic chk_out();
    cmp("gain", gainValue, eff(0) & 255);
    cmp("coarse", coarseDutyEn, eff(0) >> 8);
    cmp("duty", dutyValue, eff(1) & 255);
    cmp("carrier", carrierValue, eff(2) & 255);
    cmp("caltest", calTestEn, eff(2) >> 8);
    cmp("locked", deviceLocked, blown[3] >> 9);
    if (mSel >= 0) cmp("dac", dacCode, eff(mSel));
    rd(pcfp_pkg::OFF_STATUS, mState | (blown[3] >> 9 << 8), 0, 32'h107);
  endtask

  // One pulse; a pulse shorter than the minimum leaves the model alone.
  task automatic pulse(input int hi, input int len = 0);
    if (len == 0) len = MIN + $urandom_range(3);
    src.send(hi ? pcfp_pkg::LEVEL_HIGH : pcfp_pkg::LEVEL_MID, len, MIN + $urandom_range(4));
    if (len >= MIN) begin
      case (mState)
        0: if (hi && mEn && !(blown[3] >> 9)) mState = 1;
        1: begin
          if (!hi) begin
            mKey = (mKey < 7) ? mKey + 1 : 7;
          end else begin
            mSel = (mKey == 1) ? 0 : (mKey == 2) ? 1 : (mKey == 3) ? 2 : (mKey == 5) ? 3 : -1;
            mState = (mSel < 0) ? 3 : 2;
          end
        end
        2: begin
          if (!hi) begin
            mTry = (mTry < ((mSel == 3) ? 512 : 511)) ? mTry + 1 : mTry;
          end else begin
            blown[mSel] |= mTry;
            mState = 3;
          end
        end
        default: ;
      endcase
    end
    chk_out();
  endtask

  // Supply cycle: the sequence and unblown bits start over.
  task automatic power_cycle();
    rst_b <= 1'h0;
    repeat (16) @(posedge clk_sys);
    rst_b <= 1'h1;
    nvErase <= 1'h0;
    mState = 0;
    mKey = 0;
    mTry = 0;
    mSel = -1;
    mEn = 1;
    repeat (4) @(posedge clk_sys);
  endtask

  // Select by key, address a code, optionally blow it.
  task automatic session(input int key, input int cnt, input int blow);
    power_cycle();
    pulse(1);
    repeat (key) pulse(0);
    pulse(1);
    repeat (cnt) pulse(0);
    if (blow) pulse(1);
  endtask

  // Blow each set bit of code in its own session, rising or falling order.
  task automatic blow_bits(input int key, input int up);
    for (int i = 0; i < 8; i++) begin
      n = up ? i : 7 - i;
      if (code >> n & 1) session(key, 1 << n, 1);
    end
  endtask

  task automatic wrapUp();
    $display("checks %0d mismatches %0d", numChecks, mismatches);
    if (mismatches == 0 && numChecks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    void'($urandom(32'hC99898EF));
    power_cycle();
    rd(pcfp_pkg::OFF_CTRL, 1);
    rd(8'h1C, 0, 1);
    wr(pcfp_pkg::OFF_STATUS, 32'hFFFF_FFFF);
    rd(pcfp_pkg::OFF_STATUS, 0);
    pulse(0);
    pulse(1, MIN - 3);
    session(1, 2 + $urandom_range(20), 0);
    pulse(0, MIN - 1);
    pulse(0, MIN);
    rd(pcfp_pkg::OFF_TRY, mTry);
    power_cycle();
    chk_out();
    code = 1 + $urandom_range(254);
    blow_bits(1, 1);
    blow_bits(2, 0);
    rd(pcfp_pkg::OFF_BLOWN_GAIN, code);
    rd(pcfp_pkg::OFF_BLOWN_DUTY, code);
    session(1, 256, 1);
    session(3, 513, 0);
    session(4, 2, 0);
    pulse(1);
    power_cycle();
    wr(pcfp_pkg::OFF_CTRL, 32'h0);
    mEn = 0;
    rd(pcfp_pkg::OFF_CTRL, 0);
    pulse(1);
    session(5, 512, 1);
    power_cycle();
    pulse(1);
    rd(pcfp_pkg::OFF_BLOWN_LOCK, 512);
    wrapUp();
  end

  // A hang past the longest expected run counts as a mismatch.
  initial begin
    repeat (100000) @(posedge clk_sys);
    mismatches++;
    wrapUp();
  end
endmodule
`default_nettype wire
